// >>> ipb_bank.sv
`timescale 1ns/10ps
module ipb_bank (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic [2:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire logic [17:0] SRC_PEND,
    output logic IRQ_VALID,
    output logic [2:0] IRQ_LEVEL,
    output logic [4:0] IRQ_SOURCE
);

    // ==========================================================
    // Register storage
    // ==========================================================
    ipb_pkg::ipb_req_s req;
    logic [2:0] level_r [ipb_pkg::NUM_SRC];
    logic [2:0] level_nxt [ipb_pkg::NUM_SRC];
    logic [17:0] enable_r;
    logic [17:0] enable_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    ipb_pkg::ipb_grant_s grant_r;
    ipb_pkg::ipb_grant_s grant_nxt;

    assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    // Field slice of a written word
    function automatic logic [2:0] field_of(input logic [15:0] w, input logic [3:0] lsb);
        field_of = w[lsb +: 3];
    endfunction

    genvar g;
    generate
        for (g = 0; g < ipb_pkg::NUM_SRC; g++) begin : gen_lvl
            always_comb begin
                level_nxt[g] = level_r[g];
                if (req.wr && req.addr == ipb_pkg::SRC_REG[g]) begin
                    level_nxt[g] = field_of(req.wdata, ipb_pkg::SRC_LSB[g]);
                end
            end
            always_ff @(posedge CLOCK) begin
                if (RESET) begin
                    level_r[g] <= ipb_pkg::LEVEL_RESET;
                end else begin
                    level_r[g] <= level_nxt[g];
                end
            end
        end
    endgenerate

    // ==========================================================
    // Enables and read path
    // ==========================================================
    always_comb begin
        enable_nxt = enable_r;
        rdata_nxt = ipb_pkg::READ_ZERO;
        if (req.wr && req.addr == ipb_pkg::SOURCE_EN_LO_OFS) begin
            enable_nxt[15:0] = req.wdata;
        end
        if (req.wr && req.addr == ipb_pkg::SOURCE_EN_HI_OFS) begin
            enable_nxt[17:16] = req.wdata[1:0];
        end
        if (req.rd) begin
            for (int i = 0; i < ipb_pkg::NUM_SRC; i++) begin
                if (req.addr == ipb_pkg::SRC_REG[i]) begin
                    rdata_nxt[ipb_pkg::SRC_LSB[i] +: 3] = level_r[i];
                end
            end
            unique case (req.addr)
                ipb_pkg::SOURCE_EN_LO_OFS: rdata_nxt = enable_r[15:0];
                ipb_pkg::SOURCE_EN_HI_OFS: rdata_nxt = {14'h0000, enable_r[17:16]};
                ipb_pkg::WINNER_OFS: rdata_nxt = {7'h00, grant_r.valid,
                                                  grant_r.level, grant_r.source};
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Arbitration
    // ==========================================================
    always_comb begin
        grant_nxt = '0;
        for (int i = ipb_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (SRC_PEND[i] && enable_r[i] && level_r[i] != ipb_pkg::LEVEL_OFF
                && level_r[i] >= grant_nxt.level) begin
                grant_nxt.valid = 1'b1;
                grant_nxt.level = level_r[i];
                grant_nxt.source = 5'(i);
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            enable_r <= 18'(ipb_pkg::ENABLE_RESET);
            rdata_r <= ipb_pkg::READ_ZERO;
            grant_r <= '0;
        end else begin
            enable_r <= enable_nxt;
            rdata_r <= rdata_nxt;
            grant_r <= grant_nxt;
        end
    end

    assign RDATA = rdata_r;
    assign IRQ_VALID = grant_r.valid;
    assign IRQ_LEVEL = grant_r.level;
    assign IRQ_SOURCE = grant_r.source;

    // ==========================================================
    // Checks
    // ==========================================================
    reset_level_a: assert property (@(posedge CLOCK) $fell(RESET) |->
        level_r[0] == 3'h4 && level_r[17] == 3'h4)
        else $error("level not 4 after reset");
    disabled_src_a: assert property (@(posedge CLOCK) disable iff (RESET)
        IRQ_VALID |-> IRQ_LEVEL != 3'h0)
        else $error("level 0 granted");
    enable_gate_a: assert property (@(posedge CLOCK) disable iff (RESET)
        IRQ_VALID |-> |($past(enable_r & SRC_PEND) & (18'h00001 << IRQ_SOURCE)))
        else $error("disabled source granted");
    readback_a: assert property (@(posedge CLOCK) disable iff (RESET)
        WR && ADDR == 3'h0 ##1 RD && ADDR == 3'h0 |=>
        RDATA == ($past(WDATA, 2) & 16'h7777))
        else $error("set 0 readback wrong");
    unused_bits_a: assert property (@(posedge CLOCK) disable iff (RESET)
        $past(RD) && $past(ADDR) == 3'h3 |-> RDATA[15:11] == 5'h00)
        else $error("set 3 unused bits nonzero");
    set4_gap_a: assert property (@(posedge CLOCK) disable iff (RESET)
        $past(RD) && $past(ADDR) == 3'h4 |-> RDATA[11:7] == 5'h00)
        else $error("set 4 unused bits nonzero");
    top_level_a: assert property (@(posedge CLOCK) disable iff (RESET)
        SRC_PEND[0] && enable_r[0] && level_r[0] == 3'h7 |=>
        IRQ_VALID && IRQ_SOURCE == 5'h00)
        else $error("top source not chosen");
    write_field_a: assert property (@(posedge CLOCK) disable iff (RESET)
        WR && ADDR == 3'h2 |=> level_r[11] == $past(WDATA[2:0]))
        else $error("timer c field not written");
    rdata_idle_a: assert property (@(posedge CLOCK) disable iff (RESET)
        !$past(RD) |-> RDATA == 16'h0000)
        else $error("read data not zero outside a read");
    low_gaps_a: assert property (@(posedge CLOCK) disable iff (RESET)
        $past(RD) && $past(ADDR) <= 3'h2 |-> (RDATA & 16'h8888) == 16'h0000)
        else $error("sets 0 to 2 unused bits nonzero");
    write_set0_a: assert property (@(posedge CLOCK) disable iff (RESET)
        WR && ADDR == 3'h0 |=> level_r[0] == $past(WDATA[14:12]))
        else $error("timer a field not written");
    write_set1_a: assert property (@(posedge CLOCK) disable iff (RESET)
        WR && ADDR == 3'h1 |=> level_r[7] == $past(WDATA[2:0]))
        else $error("dma zero field not written");
    write_set3_a: assert property (@(posedge CLOCK) disable iff (RESET)
        WR && ADDR == 3'h3 |=> level_r[12] == $past(WDATA[10:8]))
        else $error("dma one field not written");
    write_set4_a: assert property (@(posedge CLOCK) disable iff (RESET)
        WR && ADDR == 3'h4 |=> level_r[16] == $past(WDATA[6:4]))
        else $error("i2c master field not written");

endmodule

// >>> ipb_pkg.sv
package ipb_pkg;

    // ==========================================================
    // Register map (word index on the plain register port)
    // ==========================================================
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;
    localparam logic [2:0] LEVEL_SET_0_OFS = 3'h0;
    localparam logic [2:0] LEVEL_SET_1_OFS = 3'h1;
    localparam logic [2:0] LEVEL_SET_2_OFS = 3'h2;
    localparam logic [2:0] LEVEL_SET_3_OFS = 3'h3;
    localparam logic [2:0] LEVEL_SET_4_OFS = 3'h4;
    localparam logic [2:0] SOURCE_EN_LO_OFS = 3'h5;
    localparam logic [2:0] SOURCE_EN_HI_OFS = 3'h6;
    localparam logic [2:0] WINNER_OFS = 3'h7;

    // ==========================================================
    // Fields
    // ==========================================================
    localparam int NUM_SRC = 18;
    localparam int LVL_W = 3;
    localparam int SRC_W = 5;
    localparam logic [2:0] LEVEL_RESET = 3'h4;
    localparam logic [2:0] LEVEL_OFF = 3'h0;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] READ_ZERO = 16'h0000;

    // Register index and low bit of each source field, in source order
    localparam logic [2:0] SRC_REG [NUM_SRC] = '{
        3'h0, 3'h0, 3'h0, 3'h0,
        3'h1, 3'h1, 3'h1, 3'h1,
        3'h2, 3'h2, 3'h2, 3'h2,
        3'h3, 3'h3, 3'h3,
        3'h4, 3'h4, 3'h4};
    localparam logic [3:0] SRC_LSB [NUM_SRC] = '{
        4'hC, 4'h8, 4'h4, 4'h0,
        4'hC, 4'h8, 4'h4, 4'h0,
        4'hC, 4'h8, 4'h4, 4'h0,
        4'h8, 4'h4, 4'h0,
        4'hC, 4'h4, 4'h0};

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } ipb_req_s;

    typedef struct packed {
        logic valid;
        logic [LVL_W-1:0] level;
        logic [SRC_W-1:0] source;
    } ipb_grant_s;

endpackage

// >>> ipb_src_model.sv
`timescale 1ns/10ps
module ipb_src_model (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire logic [17:0] want,
    output logic [17:0] SRC_PEND
);
    // ==========
    // Peripheral pending flags, registered, cleared by reset
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            SRC_PEND <= 18'h00000;
        end else begin
            SRC_PEND <= want;
        end
    end
endmodule

// >>> ipb_bank_tb.sv
`timescale 1ns/10ps
module ipb_bank_tb;
    logic CLOCK = 0, RESET = 1, WR = 0, RD = 0, rd_d = 0, IRQ_VALID;
    logic [2:0] ADDR = 3'h0, IRQ_LEVEL;
    logic [4:0] IRQ_SOURCE;
    logic [15:0] WDATA = 16'h0000, RDATA, e;
    logic [17:0] want = 18'h00000, SRC_PEND, en;
    logic [31:0] r;
    logic [15:0] sh [5];
    logic [15:0] expq [$];
    int n_fail = 0, samples_checked = 0, seed = 73;
    localparam logic [15:0] MASK [5] = '{16'h7777, 16'h7777, 16'h7777, 16'h0777, 16'h7077};
    always #50 CLOCK = ~CLOCK;
    ipb_bank ipb_bank_inst (.CLOCK(CLOCK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .SRC_PEND(SRC_PEND), .IRQ_VALID(IRQ_VALID),
        .IRQ_LEVEL(IRQ_LEVEL), .IRQ_SOURCE(IRQ_SOURCE));
    ipb_src_model ipb_src_model_inst (.CLOCK(CLOCK), .RESET(RESET), .want(want),
        .SRC_PEND(SRC_PEND));
    // ==========
    // Bus tasks and comparison
    task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
        samples_checked++;
        if (g !== x) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        ADDR <= a; WDATA <= d; WR <= 1'b1; RD <= 1'b0;
        @(posedge CLOCK);
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] x);
        ADDR <= a; RD <= 1'b1; WR <= 1'b0; expq.push_back(x);
        @(posedge CLOCK);
    endtask
    task automatic idle();
        WR <= 1'b0; RD <= 1'b0;
        @(posedge CLOCK);
    endtask
    always @(posedge CLOCK) begin
        rd_d <= RD;
        if (rd_d) begin
            chk("RDATA", expq.pop_front(), RDATA);
        end
    end
    // Highest nonzero level among pending enabled sources, lowest index on a tie
    function automatic logic [15:0] winner(input logic [17:0] p);
        logic [2:0] bl, l;
        logic [4:0] bs;
        bl = 3'h0; bs = 5'h00;
        for (int s = 0; s < 18; s++) begin
            l = sh[ipb_pkg::SRC_REG[s]][ipb_pkg::SRC_LSB[s] +: 3];
            if (p[s] && en[s] && l > bl) begin
                bl = l; bs = 5'(s);
            end
        end
        return (bl == 3'h0) ? 16'h0000 : {7'h00, 1'b1, bl, bs};
    endfunction
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge CLOCK);
        n_fail++;
        tally_and_finish();
    end
    // ==========
    // Scenarios
    initial begin
        repeat (10) @(posedge CLOCK);
        RESET <= 1'b0;
        @(posedge CLOCK);
        for (int i = 0; i < 5; i++) rd(3'(i), 16'h4444 & MASK[i]);
        rd(3'h5, 16'h0000);
        $display("reset values test ended");
        for (int i = 0; i < 5; i++) begin
            wr(3'(i), 16'hFFFF);
            rd(3'(i), MASK[i]);
        end
        wr(3'h7, 16'hFFFF);
        rd(3'h7, 16'h0000);
        $display("access test ended");
        repeat (40) begin
            for (int i = 0; i < 5; i++) begin
                r = $random(seed);
                sh[i] = r[15:0] & MASK[i];
                wr(3'(i), sh[i]);
                rd(3'(i), sh[i]);
            end
            r = $random(seed);
            en = r[17:0];
            wr(3'h5, en[15:0]);
            wr(3'h6, {14'h0000, en[17:16]});
            idle();
            r = $random(seed);
            want <= r[17:0];
            e = winner(r[17:0]);
            repeat (4) @(posedge CLOCK);
            #10 chk("IRQ", e, {7'h00, IRQ_VALID, IRQ_LEVEL, IRQ_SOURCE});
            @(posedge CLOCK);
            rd(3'h7, e);
        end
        $display("arbitration test ended");
        idle();
        RESET <= 1'b1;
        @(posedge CLOCK);
        RESET <= 1'b0;
        @(posedge CLOCK);
        rd(3'h4, 16'h4044);
        idle();
        @(posedge CLOCK);
        $display("second reset test ended");
        tally_and_finish();
    end
endmodule
